// [src/bssf_pkg.sv]
// Shared constants, types and CRC helpers for the byte-sync serial framer
package bssf_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_SYNC = 8'h08;
  localparam logic [7:0] A_CMD  = 8'h0C;
  localparam logic [7:0] A_TXD  = 8'h10;
  localparam logic [7:0] A_RXD  = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam int PROTO_LSB  = 0;
  localparam int CRCEN_BIT  = 2;
  localparam int CRCSEL_LSB = 3;
  localparam int IDLSRC_BIT = 0;
  localparam int SYNLD_BIT  = 1;
  localparam int UDRC_BIT   = 2;
  localparam int SYN0_LSB   = 0;
  localparam int SYN1_LSB   = 8;
  localparam int IDLE_LSB   = 16;
  localparam int ST_TX_READY_FLAG   = 0;
  localparam int ST_RXAV    = 1;
  localparam int ST_UNDERRUN_FLAG    = 2;
  localparam int ST_CRC_ERROR_FLAG    = 3;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SYNC_RST = 32'h00FF_FFFF;
  localparam logic [1:0] PROTO_MONO = 2'h0;
  localparam logic [1:0] PROTO_BI   = 2'h1;
  localparam logic [1:0] PROTO_EXT  = 2'h2;
  localparam logic [15:0] POLY_16 = 16'h8005;
  localparam logic [15:0] POLY_CC = 16'h1021;
  localparam logic [3:0] CRC_CHECK_CLKS = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic chan_rst;
    logic crc_force;
    logic msg_reject;
    logic rx_crc_excl;
    logic rx_crc_init;
    logic tx_crc_excl;
    logic tx_crc_init;
    logic end_msg;
    logic rx_rst;
    logic rx_dis;
    logic rx_en;
    logic tx_rst;
    logic tx_dis;
    logic tx_en;
  } bssf_cmd_type;
  typedef enum logic [2:0] {TX_DIS, TX_IDLE, TX_SYN1, TX_SYN2, TX_CHAR, TX_CRC} bssf_txst_type;
  typedef enum logic [1:0] {RX_DIS, RX_HUNT1, RX_HUNT2, RX_CHAR} bssf_rxst_type;
  // Bits enter LSB first, register shifts toward its MSB
  function automatic logic [15:0] bssf_crc8(input logic [15:0] c, input logic [7:0] d, input logic cc);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) r = r ^ (cc ? POLY_CC : POLY_16);
    end
    return r;
  endfunction
  function automatic logic [31:0] bssf_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction
endpackage

// [src/bssf_top.sv]
// Byte-sync serial framer with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module bssf_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [bssf_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [bssf_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       tx_clk,
  input  wire logic                       rx_clk,
  input  wire logic                       rxd,
  input  wire logic                       sync_n,
  output logic                            txd
);
  import bssf_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [31:0]   mode_q, ctrl_q, sync_q;
  bssf_cmd_type  cmd_q;
  logic [3:0]    pin_in, sy_a_q, sy_b_q;
  logic          tclk_p_q, rclk_p_q, tx_tick, rx_tick, rxd_s, syn_s;
  logic [1:0]    proto, crc_sel;
  logic          bi, ext, crc_en, idle_src, syn_ld, udr_crc;
  logic [7:0]    syn0, syn1, idle_pat;
  logic [15:0]   crc_init_v;
  logic          awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q, wdata_q, rd_v;
  logic [3:0]    wstrb_q;
  logic [7:0]    awaddr_q, wa, ra;
  logic          aw_have_q, w_have_q, wr_go, rd_rx;
  logic          we_mode, we_ctrl, we_sync, we_cmd, we_txd, we_stat;
  bssf_txst_type tx_st_q, tx_nst;
  logic          txd_q, tx_full_q, tx_ready_flag_q, underrun_flag_q, eom_q, txdis_q, txexcl_q;
  logic [7:0]    tx_sh_q, tx_buf_q, tx_nbyte;
  logic [2:0]    tx_cnt_q;
  logic [15:0]   tx_crc_q, tx_base;
  logic          tx_crc_byte_q, tx_kill, tx_bnd, tx_take, tx_take_now;
  logic          tx_fetch, tx_uflow, tx_cinit;
  bssf_rxst_type rx_st_q;
  logic [7:0]    rx_sh_q, sh_n, rx_data_q, rx_b1_q, rx_b0_q;
  logic [2:0]    rx_cnt_q;
  logic [15:0]   rx_crc_q, rx_base, rx_h1_q, rx_h2_q;
  logic          rx_kill, rx_avail_q, rxexcl_q, rx_byte_now, rx_is_syn, rx_store;
  logic [3:0]    chk_cnt_q;
  logic          crc_err_q;
  logic [4:0]    age_q;

  // Pin and link-clock synchronisers
  assign pin_in = {sync_n, rxd, rx_clk, tx_clk};
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sy_a_q[g] <= 1'b1;
        sy_b_q[g] <= 1'b1;
      end else begin
        sy_a_q[g] <= pin_in[g];
        sy_b_q[g] <= sy_a_q[g];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tclk_p_q <= 1'b1;
      rclk_p_q <= 1'b1;
    end else begin
      tclk_p_q <= sy_b_q[0];
      rclk_p_q <= sy_b_q[1];
    end
  end

  // Transmit on falling link edge, sample on rising
  assign tx_tick = tclk_p_q & ~sy_b_q[0];
  assign rx_tick = ~rclk_p_q & sy_b_q[1];
  assign rxd_s   = sy_b_q[2];
  assign syn_s   = sy_b_q[3];

  assign proto      = mode_q[PROTO_LSB +: 2];
  assign bi         = (proto == PROTO_BI);
  assign ext        = (proto == PROTO_EXT);
  assign crc_en     = mode_q[CRCEN_BIT];
  assign crc_sel    = mode_q[CRCSEL_LSB +: 2];
  assign idle_src   = ctrl_q[IDLSRC_BIT];
  assign syn_ld     = ctrl_q[SYNLD_BIT];
  assign udr_crc    = ctrl_q[UDRC_BIT];
  assign syn0       = sync_q[SYN0_LSB +: 8];
  assign syn1       = sync_q[SYN1_LSB +: 8];
  assign idle_pat   = sync_q[IDLE_LSB +: 8];
  assign crc_init_v = {16{crc_sel[1]}};

  // AXI4-Lite write channel
  assign wa    = {awaddr_q[ADDR_W-1:2], 2'b00};
  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q  <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        bresp_q   <= (wa <= A_STAT) ? RESP_OKAY : RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign we_mode = wr_go & (wa == A_MODE);
  assign we_ctrl = wr_go & (wa == A_CTRL);
  assign we_sync = wr_go & (wa == A_SYNC);
  assign we_cmd  = wr_go & (wa == A_CMD);
  assign we_txd  = wr_go & (wa == A_TXD) & wstrb_q[0];
  assign we_stat = wr_go & (wa == A_STAT) & wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_RST;
      ctrl_q <= CTRL_RST;
      sync_q <= SYNC_RST;
    end else begin
      if (we_mode) mode_q <= bssf_merge(mode_q, wdata_q, wstrb_q);
      if (we_ctrl) ctrl_q <= bssf_merge(ctrl_q, wdata_q, wstrb_q);
      if (we_sync) sync_q <= bssf_merge(sync_q, wdata_q, wstrb_q);
    end
  end

  // Commands live one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) cmd_q <= '0;
    else if (we_cmd) cmd_q <= bssf_cmd_type'(wdata_q[13:0]);
    else cmd_q <= '0;
  end

  // AXI4-Lite read channel
  assign ra    = {araddr[ADDR_W-1:2], 2'b00};
  assign rd_rx = arvalid & arready_q & (ra == A_RXD);

  always_comb begin
    rd_v = 32'h0000_0000;
    case (ra)
      A_MODE: rd_v = mode_q;
      A_CTRL: rd_v = ctrl_q;
      A_SYNC: rd_v = sync_q;
      A_TXD:  rd_v[7:0] = tx_buf_q;
      A_RXD:  rd_v[7:0] = rx_data_q;
      A_STAT: begin
        rd_v[ST_TX_READY_FLAG] = tx_ready_flag_q;
        rd_v[ST_RXAV]  = rx_avail_q;
        rd_v[ST_UNDERRUN_FLAG]  = underrun_flag_q;
        rd_v[ST_CRC_ERROR_FLAG]  = crc_err_q;
      end
      default: rd_v = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      rvalid_q  <= 1'b1;
      arready_q <= 1'b0;
      rdata_q   <= rd_v;
      rresp_q   <= (ra <= A_STAT) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (rvalid_q && rready) rvalid_q <= 1'b0;
      if (!rvalid_q && !arready_q) arready_q <= 1'b1;
    end
  end

  // Transmit byte-boundary decision
  assign tx_kill     = cmd_q.tx_rst | cmd_q.chan_rst;
  assign tx_bnd      = tx_tick & (tx_cnt_q == 3'h7) & (tx_st_q != TX_DIS);
  assign tx_take_now = tx_bnd & tx_take;

  always_comb begin
    tx_nst   = tx_st_q;
    tx_nbyte = idle_src ? idle_pat : 8'hFF;
    tx_take  = 1'b0;
    tx_uflow = 1'b0;
    tx_fetch = 1'b0;
    unique case (tx_st_q)
      TX_DIS: tx_nbyte = 8'hFF;
      TX_IDLE: begin
        if (txdis_q && !tx_full_q) begin
          tx_nst   = TX_DIS;
          tx_nbyte = 8'hFF;
        end else if (tx_full_q && !underrun_flag_q) begin
          tx_nst   = TX_SYN1;
          tx_nbyte = syn1;
        end
      end
      TX_SYN1: begin
        if (bi) begin
          tx_nst   = TX_SYN2;
          tx_nbyte = syn0;
        end else begin
          tx_fetch = 1'b1;
        end
      end
      TX_SYN2: tx_fetch = 1'b1;
      TX_CHAR: tx_fetch = 1'b1;
      TX_CRC: begin
        // low byte then resume or idle
        if (!tx_crc_byte_q) begin
          tx_nbyte = tx_crc_q[7:0];
        end else if (tx_full_q) begin
          tx_nst   = TX_SYN1;
          tx_nbyte = syn1;
        end else begin
          tx_nst = TX_IDLE;
        end
      end
    endcase
    if (tx_fetch) begin
      if (tx_full_q) begin
        tx_nst   = TX_CHAR;
        tx_nbyte = tx_buf_q;
        tx_take  = 1'b1;
      end else begin
        // CRC on message end or underrun
        tx_uflow = ~eom_q;
        if (crc_en && (eom_q || udr_crc)) begin
          tx_nst   = TX_CRC;
          tx_nbyte = tx_crc_q[15:8];
        end else begin
          tx_nst = TX_IDLE;
        end
      end
    end
  end

  assign tx_cinit = tx_fetch & (tx_st_q != TX_CHAR);

  // external mode sends one sync byte like mono
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_kill) begin
      tx_st_q       <= TX_DIS;
      txd_q         <= 1'b1;
      tx_sh_q       <= 8'hFF;
      tx_cnt_q      <= 3'h7;
      tx_crc_byte_q <= 1'b0;
    end else if (tx_st_q == TX_DIS) begin
      txd_q    <= 1'b1;
      tx_cnt_q <= 3'h7;
      if (cmd_q.tx_en) tx_st_q <= TX_IDLE;
    end else if (tx_tick) begin
      if (tx_cnt_q == 3'h7) begin
        tx_st_q       <= tx_nst;
        txd_q         <= tx_nbyte[0];
        tx_sh_q       <= {1'b1, tx_nbyte[7:1]};
        tx_cnt_q      <= 3'h0;
        tx_crc_byte_q <= (tx_st_q == TX_CRC) & ~tx_crc_byte_q;
      end else begin
        txd_q    <= tx_sh_q[0];
        tx_sh_q  <= {1'b1, tx_sh_q[7:1]};
        tx_cnt_q <= tx_cnt_q + 3'h1;
      end
    end
  end

  // A write to a full buffer is dropped unless the byte leaves that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_kill) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else if (we_txd && (!tx_full_q || tx_take_now)) begin
      tx_full_q <= 1'b1;
      tx_buf_q  <= wdata_q[7:0];
    end else if (tx_take_now) begin
      tx_full_q <= 1'b0;
    end
  end

  // ready drops while underrun flag stands
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_ready_flag_q <= 1'b0;
    else tx_ready_flag_q <= (tx_st_q != TX_DIS) & ~tx_full_q & ~underrun_flag_q & ~tx_kill;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || tx_kill) begin
      eom_q    <= 1'b0;
      txdis_q  <= 1'b0;
      txexcl_q <= 1'b0;
    end else begin
      if (cmd_q.end_msg) eom_q <= 1'b1;
      else if (tx_bnd && tx_fetch && !tx_full_q) eom_q <= 1'b0;
      if (cmd_q.tx_dis) txdis_q <= 1'b1;
      else if (cmd_q.tx_en || tx_st_q == TX_DIS) txdis_q <= 1'b0;
      if (cmd_q.tx_crc_excl) txexcl_q <= 1'b1;
      else if (tx_take_now) txexcl_q <= 1'b0;
    end
  end

  // preset at data start or command
  assign tx_base = (cmd_q.tx_crc_init || (tx_bnd && tx_cinit)) ? crc_init_v : tx_crc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) tx_crc_q <= 16'h0000;
    else if (tx_take_now && !txexcl_q) tx_crc_q <= bssf_crc8(tx_base, tx_buf_q, crc_sel[0]);
    else tx_crc_q <= tx_base;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_q.chan_rst) underrun_flag_q <= 1'b0;
    else if (tx_bnd && tx_uflow) underrun_flag_q <= 1'b1;
    else if (we_stat && wdata_q[ST_UNDERRUN_FLAG]) underrun_flag_q <= 1'b0;
  end

  // Receiver
  assign rx_kill     = cmd_q.rx_rst | cmd_q.rx_dis | cmd_q.chan_rst;
  assign sh_n        = {rxd_s, rx_sh_q[7:1]};
  assign rx_byte_now = rx_tick & (rx_st_q == RX_CHAR) & (rx_cnt_q == 3'h7) & ~cmd_q.msg_reject;
  assign rx_is_syn   = (sh_n == syn0) | (bi & (sh_n == syn1));
  // data-field sync kept only when loading
  assign rx_store    = rx_byte_now & (~rx_is_syn | syn_ld);

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_kill) begin
      rx_st_q  <= RX_DIS;
      rx_sh_q  <= 8'hFF;
      rx_cnt_q <= 3'h0;
    end else if (rx_st_q == RX_DIS) begin
      if (cmd_q.rx_en) rx_st_q <= RX_HUNT1;
    end else if (rx_st_q == RX_CHAR && cmd_q.msg_reject) begin
      rx_st_q <= RX_HUNT1;
    end else if (rx_st_q == RX_HUNT1 && ext && !syn_s) begin
      rx_st_q  <= RX_CHAR;
      rx_cnt_q <= 3'h0;
    end else if (rx_tick) begin
      rx_sh_q  <= sh_n;
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (rx_st_q == RX_HUNT1 && !ext && sh_n == syn0) begin
        rx_st_q  <= bi ? RX_HUNT2 : RX_CHAR;
        rx_cnt_q <= 3'h0;
      // second byte must match sync one
      end else if (rx_st_q == RX_HUNT2 && rx_cnt_q == 3'h7) begin
        rx_st_q <= (sh_n == syn1) ? RX_CHAR : RX_HUNT1;
      end
    end
  end

  // store to receive buffer, store beats read
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_q.chan_rst) begin
      rx_avail_q <= 1'b0;
      rx_data_q  <= 8'h00;
    end else if (rx_store) begin
      rx_avail_q <= 1'b1;
      rx_data_q  <= sh_n;
    end else if (rd_rx) begin
      rx_avail_q <= 1'b0;
    end
  end

  // preset outside data field or on command
  assign rx_base = (cmd_q.rx_crc_init || rx_st_q != RX_CHAR) ? crc_init_v : rx_crc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_crc_q <= 16'h0000;
      rx_h1_q  <= 16'h0000;
      rx_h2_q  <= 16'h0000;
      rx_b1_q  <= 8'h00;
      rx_b0_q  <= 8'h00;
    end else begin
      rx_crc_q <= (rx_store && !rxexcl_q) ? bssf_crc8(rx_base, sh_n, crc_sel[0]) : rx_base;
      if (rx_store) begin
        rx_h1_q <= rx_base;
        rx_h2_q <= rx_h1_q;
        rx_b1_q <= sh_n;
        rx_b0_q <= rx_b1_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rx_kill) rxexcl_q <= 1'b0;
    else if (cmd_q.rx_crc_excl) rxexcl_q <= 1'b1;
    else if (rx_store) rxexcl_q <= 1'b0;
  end

  // check delay from store or force
  always_ff @(posedge aclk) begin
    if (!aresetn) chk_cnt_q <= 4'h0;
    else if (rx_store || cmd_q.crc_force) chk_cnt_q <= CRC_CHECK_CLKS;
    else if (chk_cnt_q != 4'h0) chk_cnt_q <= chk_cnt_q - 4'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_q.chan_rst) crc_err_q <= 1'b0;
    else if (rx_store) crc_err_q <= 1'b0;
    else if (chk_cnt_q == 4'h1) crc_err_q <= crc_en & (rx_h2_q != {rx_b0_q, rx_b1_q});
  end

  // Assertion helper: cycles since last store or force
  always_ff @(posedge aclk) begin
    if (!aresetn) age_q <= 5'h1F;
    else if (rx_store || cmd_q.crc_force) age_q <= 5'h00;
    else if (age_q != 5'h1F) age_q <= age_q + 5'h01;
  end

  sequence s_syn1_bi;
    tx_bnd && tx_st_q == TX_SYN1 && bi && !tx_kill;
  endsequence
  sequence s_underrun_flag_hit;
    tx_bnd && tx_uflow && !tx_kill;
  endsequence

  chk_tx_dis_line: assert property (tx_st_q == TX_DIS && $past(tx_st_q == TX_DIS) |-> txd_q && !tx_ready_flag_q)
    else $error("disabled transmitter not at mark or ready set");
  chk_tx_enable: assert property (tx_st_q == TX_DIS && cmd_q.tx_en && !tx_kill |=> tx_st_q == TX_IDLE)
    else $error("enable did not reach idle");
  chk_idle_mark: assert property (tx_bnd && tx_st_q == TX_IDLE && tx_nst == TX_IDLE && !idle_src |=> txd_q)
    else $error("idle without pattern not at mark");
  chk_syn_order: assert property (s_syn1_bi |=> tx_st_q == TX_SYN2 && txd_q == $past(syn0[0]))
    else $error("bi-sync did not move to second sync");
  chk_syn2_bi: assert property ($rose(tx_st_q == TX_SYN2) |-> $past(bi))
    else $error("second sync outside bi-sync");
  chk_crc_two: assert property ($fell(tx_st_q == TX_CRC) && tx_st_q != TX_DIS |-> $past(tx_crc_byte_q))
    else $error("CRC state left before second byte");
  chk_underrun_flag_set: assert property (s_underrun_flag_hit |=> underrun_flag_q ##1 !tx_ready_flag_q)
    else $error("underrun did not set flag and drop ready");
  chk_resume_clr: assert property (tx_st_q == TX_IDLE && underrun_flag_q |=> tx_st_q != TX_SYN1)
    else $error("restart while underrun flag set");
  chk_rx_dis: assert property ($rose(rx_avail_q) |-> $past(rx_st_q) == RX_CHAR)
    else $error("receive data outside data state");
  chk_rx_reject: assert property (rx_st_q == RX_CHAR && cmd_q.msg_reject && !rx_kill |=> rx_st_q == RX_HUNT1)
    else $error("reject did not restart hunt");
  chk_crc_delay: assert property ($rose(crc_err_q) |-> $past(age_q) == 5'h0E)
    else $error("CRC result at wrong delay");

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign txd     = txd_q;
endmodule

// [verification/bssf_remote.sv]
// Remote sync station: link clocks, serial source and sink
`timescale 1ns/1ps
module bssf_remote (
  output logic        tx_clk,
  output logic        rx_clk,
  output logic        rxd,
  output logic        sync_n,
  input  wire logic   txd,
  output logic [31:0] frame,
  output logic        frame_done
);
  logic [5:0] n;
  initial begin
    tx_clk = 1'b1;
    rx_clk = 1'b1;
    rxd = 1'b1;
    sync_n = 1'b1;
    frame = 32'h0;
    frame_done = 1'b0;
    n = 6'h00;
  end
  // Link clocks run free, phase unrelated to the system clock
  always #160 tx_clk = ~tx_clk;
  initial #53 forever #160 rx_clk = ~rx_clk;
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge rx_clk);
      rxd = b[i];
    end
    @(posedge rx_clk);
  endtask
  // Line returns to mark off the sampling edge, not at it
  task automatic release_line();
    @(negedge rx_clk);
    rxd = 1'b1;
  endtask
  // Frame opens at first space; sampled late since txd lags the clock
  always @(negedge tx_clk) begin
    frame_done <= 1'b0;
    if (n != 6'h00 || txd === 1'b0) begin
      frame <= {txd, frame[31:1]};
      n <= (n == 6'h1F) ? 6'h00 : n + 6'h01;
      frame_done <= (n == 6'h1F);
    end
  end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the byte-sync serial framer
`timescale 1ns/1ps
module tb_top;
  import bssf_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tx_clk, rx_clk, rxd, sync_n, txd, frame_done;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] frame;
  logic [15:0] c;
  logic [33:0] exp_rd[$];
  logic [33:0] exp_fr[$];
  logic [7:0]  s1, d1, d2;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          seed = 87;
  always #20 aclk = ~aclk;
  bssf_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .tx_clk, .rx_clk, .rxd, .sync_n, .txd);
  bssf_remote rem (.tx_clk, .rx_clk, .rxd, .sync_n, .txd, .frame, .frame_done);
  task automatic cmp(input logic [33:0] e, input logic [33:0] got);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask
  always @(posedge aclk) if (rvalid && rready) cmp(exp_rd.pop_front(), {rresp, rdata});
  always @(posedge frame_done) cmp(exp_fr.pop_front(), {2'h0, frame});
  // Reference CRC: data bits LSB first into an MSB-out register
  function automatic logic [15:0] crc_ref(input logic [15:0] c0, input logic [7:0] d, input logic [15:0] p);
    logic [15:0] r;
    r = c0;
    for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? p : 16'h0000);
    return r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
    end while (arvalid || rready);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Whole run needs under two thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_MODE, {RESP_OKAY, MODE_RST});
    rd(A_SYNC, {RESP_OKAY, SYNC_RST});
    rd(A_STAT, {RESP_OKAY, 32'h0});
    rd(8'h1C, {RESP_SLVERR, 32'h0});
    $display("test registers done");
    s1 = 8'($random(seed)) & 8'hFE;
    d1 = 8'($random(seed));
    d2 = 8'($random(seed)) & 8'h3F;
    wr(A_SYNC, {8'h0, 8'hFF, s1, 8'h7E});
    wr(A_CMD, 32'h9);
    exp_fr.push_back({2'h0, 16'hFFFF, d1, s1});
    wr(A_TXD, {24'h0, d1});
    while (exp_fr.size() != 0) @(posedge aclk);
    // Underrun flag is set while the trailing idle bits go out
    repeat (8) @(posedge aclk);
    rd(A_STAT, {RESP_OKAY, 32'h4});
    wr(A_STAT, 32'h4);
    rd(A_STAT, {RESP_OKAY, 32'h1});
    // CRC-16 with ones preset, closed by end of message
    c = crc_ref(16'hFFFF, d1, POLY_16);
    wr(A_MODE, 32'h14);
    exp_fr.push_back({2'h0, c[7:0], c[15:8], d1, s1});
    wr(A_TXD, {24'h0, d1});
    wr(A_CMD, 32'h40);
    while (exp_fr.size() != 0) @(posedge aclk);
    repeat (8) @(posedge aclk);
    rd(A_STAT, {RESP_OKAY, 32'h1});
    // Bi-sync: sync one, sync zero, data, then underrun to idle
    wr(A_MODE, 32'h1);
    exp_fr.push_back({2'h0, 8'hFF, d1, 8'h7E, s1});
    wr(A_TXD, {24'h0, d1});
    while (exp_fr.size() != 0) @(posedge aclk);
    $display("test transmit done");
    wr(A_MODE, 32'hC);
    wr(A_CTRL, 32'h2);
    rem.send_byte(8'h7E);
    rem.send_byte(d2);
    rem.release_line();
    // Two-stage synchronisers plus store delay
    repeat (8) @(posedge aclk);
    rd(A_RXD, {RESP_OKAY, 24'h0, d2});
    $display("test receive done");
    // CRC-CCITT, zeros preset: good check bytes, then a corrupted low byte
    c = crc_ref(16'h0000, d2, POLY_CC);
    for (int k = 0; k < 2; k++) begin
      wr(A_CMD, 32'h800);
      rem.send_byte(8'h7E);
      rem.send_byte(d2);
      rem.send_byte(c[15:8]);
      rem.send_byte(c[7:0] ^ 8'(k));
      rem.release_line();
      repeat (24) @(posedge aclk);
      rd(A_STAT, {RESP_OKAY, 28'h0, k[0], 3'h6});
    end
    $display("test crc check done");
    tally_and_finish();
  end
endmodule
